//--- include/fwg_pkg.sv
// Package with geometry, register map, command and result codes
package fwg_pkg;
    // Array geometry
    localparam int ADDR_W = 26;
    localparam int SECT_W = 10;
    localparam int NUM_SECT = 1024;
    localparam int SECT_LSB = 16;
    localparam int SUB_LSB = 12;
    localparam int PAGE_LSB = 8;
    localparam int DIE_BIT = 25;
    localparam int OTP_W = 6;
    localparam logic [3:0] BP_ALL = 4'hb;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // Register byte offsets
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    localparam logic [7:0] OFF_CMD = 8'h0c;
    localparam logic [7:0] OFF_RESULT = 8'h10;
    localparam logic [7:0] OFF_LOCK = 8'h14;
    // Field positions
    localparam int ST_TB = 4;
    localparam int ST_WEL = 5;
    localparam int ST_LDN = 6;
    localparam int ST_RDY = 7;
    localparam int ST_WP = 8;
    localparam int CMD_CNT_LSB = 4;
    localparam int CMD_CNT_W = 12;
    localparam int LK_LOCK = 0;
    localparam int LK_DOWN = 1;
    // Power-on inhibit time
    localparam int POR_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // Commands
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_WREN = 4'h1,
        OP_WRDI = 4'h2,
        OP_WRSR = 4'h3,
        OP_WRLR = 4'h4,
        OP_PROG = 4'h5,
        OP_SUB_ERASE = 4'h6,
        OP_SECT_ERASE = 4'h7,
        OP_DIE_ERASE = 4'h8,
        OP_OTP_PROG = 4'h9
    } fwg_op_t;
    // Results
    typedef enum logic [2:0] {
        RES_OK = 3'h0,
        RES_POR = 3'h1,
        RES_COUNT = 3'h2,
        RES_NO_WEL = 3'h3,
        RES_PROT = 3'h4,
        RES_LOCKDOWN = 3'h5,
        RES_BAD_OP = 3'h6,
        RES_WP = 3'h7
    } fwg_res_t;
endpackage

//--- verilog/fwg_guard.sv
// Write guard for a stacked serial NOR array, with APB register access
//
// Summary of operation
// - Program only clears bits; each page programs on its own.
// - Erase sets bits; subsector, sector or die only, never a page.
// - Erased region reads all ones afterwards.
// - 1024 sectors, 16384 subsectors, 262144 pages from address bits.
// - Two dies; die erase covers one die only.
// - 64-byte OTP area kept apart from main array addresses.
// - Modifying commands need a clock count that is a multiple of eight.
// - Modifying commands need the write enable latch set beforehand.
// - Reset and power-on timer inhibit every modification.
// - Set sector lock bit blocks program and erase of that sector.
// - Lock-down freezes sector lock state until reset.
// - Lock bits change only by lock write, refused under lock-down.
// - Bottom-flag clear: codes 1..10 protect top 2^(code-1) sectors.
// - Bottom-flag set: codes 1..10 protect lowest 2^(code-1) sectors.
// - Sectors outside the protect range stay modifiable.
// - Write-protect pin low locks the protect-range setting.
`timescale 1ns/10ps
module fwg_guard #(
    parameter int POR_CYCLES = fwg_pkg::POR_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Write protect pin
    input wire logic wp_n,
    // Array byte currently at the program target
    input wire logic [7:0] cur_byte,
    // Granted array operation
    output logic op_valid,
    output logic [3:0] op_kind,
    output logic op_otp,
    output logic [25:0] op_start,
    output logic [25:0] op_end,
    output logic [7:0] op_byte
);
    localparam int AW = fwg_pkg::ADDR_W;
    localparam int SW = fwg_pkg::SECT_W;

    logic wp_s1_reg;
    logic wp_s2_reg;
    logic [15:0] por_cnt_reg;
    logic por_done_reg;
    logic [3:0] bp_reg;
    logic tb_reg;
    logic wel_reg;
    logic lockdown_reg;
    logic [fwg_pkg::NUM_SECT-1:0] lock_reg;
    logic [SW-1:0] lock_cnt0_reg;
    logic [SW-1:0] lock_cnt1_reg;
    logic [AW-1:0] addr_reg;
    logic [7:0] data_reg;
    logic [2:0] res_reg;
    logic res_done_reg;

    // Bus phases
    logic acc;
    logic wr;
    logic setup;
    assign acc = psel & penable & pready;
    assign wr = acc & pwrite;
    assign setup = psel & ~penable;

    // Write-protect pin synchroniser
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wp_s1_reg <= 1'b1;
            wp_s2_reg <= 1'b1;
        end else begin
            wp_s1_reg <= wp_n;
            wp_s2_reg <= wp_s1_reg;
        end
    end

    // Power-on inhibit timer
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            por_cnt_reg <= 16'h0000;
            por_done_reg <= 1'b0;
        end else if (!por_done_reg) begin
            por_cnt_reg <= por_cnt_reg + 16'h0001;
            if (por_cnt_reg >= 16'(POR_CYCLES - 1)) begin
                por_done_reg <= 1'b1;
            end
        end
    end

    // Protect-range test for one sector
    function automatic logic bp_hit(input logic [3:0] code,
                                    input logic tb,
                                    input logic [SW-1:0] sect);
        logic [SW:0] n;
        logic [SW:0] s;
        n = 11'h000;
        s = {1'b0, sect};
        bp_hit = 1'b0;
        if (code >= fwg_pkg::BP_ALL) begin
            bp_hit = 1'b1;
        end else if (code != 4'h0) begin
            n = 11'h001 << (code - 4'h1);
            if (tb) begin
                bp_hit = s < n;
            end else begin
                bp_hit = s >= (11'(fwg_pkg::NUM_SECT) - n);
            end
        end
    endfunction

    // Decode of the command register write
    fwg_pkg::fwg_op_t op;
    logic [fwg_pkg::CMD_CNT_W-1:0] cnt;
    logic [SW-1:0] sect;
    logic die;
    logic cmd_wr;
    logic modifying;
    logic sect_prot;
    logic die_prot;
    logic [2:0] res;
    assign op = fwg_pkg::fwg_op_t'(pwdata[3:0]);
    assign cnt = pwdata[fwg_pkg::CMD_CNT_LSB +: fwg_pkg::CMD_CNT_W];
    assign sect = addr_reg[AW-1:fwg_pkg::SECT_LSB];
    assign die = addr_reg[fwg_pkg::DIE_BIT];
    assign cmd_wr = wr && (paddr == fwg_pkg::OFF_CMD);
    assign modifying = (op != fwg_pkg::OP_WREN) && (op != fwg_pkg::OP_NOP)
        && (op != fwg_pkg::OP_WRDI);
    assign sect_prot = bp_hit(bp_reg, tb_reg, sect)
        | lock_reg[sect];
    // Range of codes 1..10 lies in die 1 when top, die 0 when bottom
    assign die_prot = ((bp_reg >= fwg_pkg::BP_ALL)
        || ((bp_reg != 4'h0) && (die == ~tb_reg))
        || (die ? (lock_cnt1_reg != '0) : (lock_cnt0_reg != '0)));

    always_comb begin
        res = fwg_pkg::RES_OK;
        if (!por_done_reg && (modifying || op == fwg_pkg::OP_WREN)) begin
            res = fwg_pkg::RES_POR;
        end else if (modifying && cnt[2:0] != 3'h0) begin
            res = fwg_pkg::RES_COUNT;
        end else if (op > fwg_pkg::OP_OTP_PROG) begin
            res = fwg_pkg::RES_BAD_OP;
        end else if (modifying && !wel_reg) begin
            res = fwg_pkg::RES_NO_WEL;
        end else if (op == fwg_pkg::OP_WRSR && !wp_s2_reg) begin
            res = fwg_pkg::RES_WP;
        end else if (op == fwg_pkg::OP_WRLR && lockdown_reg) begin
            res = fwg_pkg::RES_LOCKDOWN;
        end else if ((op == fwg_pkg::OP_PROG
                || op == fwg_pkg::OP_SUB_ERASE
                || op == fwg_pkg::OP_SECT_ERASE) && sect_prot) begin
            res = fwg_pkg::RES_PROT;
        end else if (op == fwg_pkg::OP_DIE_ERASE && die_prot) begin
            res = fwg_pkg::RES_PROT;
        end
    end

    logic go;
    assign go = cmd_wr && (res == fwg_pkg::RES_OK);

    // Address and data holding registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            addr_reg <= '0;
            data_reg <= 8'h00;
        end else begin
            if (wr && paddr == fwg_pkg::OFF_ADDR) begin
                addr_reg <= pwdata[AW-1:0];
            end
            if (wr && paddr == fwg_pkg::OFF_DATA) begin
                data_reg <= pwdata[7:0];
            end
        end
    end

    // Write enable latch
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wel_reg <= 1'b0;
        end else if (cmd_wr && res != fwg_pkg::RES_COUNT
                && res != fwg_pkg::RES_POR) begin
            if (op == fwg_pkg::OP_WREN) begin
                wel_reg <= 1'b1;
            end else if (modifying || op == fwg_pkg::OP_WRDI) begin
                wel_reg <= 1'b0;
            end
        end
    end

    // Protect-range setting
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bp_reg <= 4'h0;
            tb_reg <= 1'b0;
        end else if (go && op == fwg_pkg::OP_WRSR) begin
            bp_reg <= data_reg[3:0];
            tb_reg <= data_reg[fwg_pkg::ST_TB];
        end
    end

    // Sector lock bits, lock-down and per-die lock counts
    logic lk_upd;
    logic lk_new;
    assign lk_upd = go && op == fwg_pkg::OP_WRLR;
    assign lk_new = data_reg[fwg_pkg::LK_LOCK];

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lock_reg <= '0;
            lockdown_reg <= 1'b0;
            lock_cnt0_reg <= '0;
            lock_cnt1_reg <= '0;
        end else if (lk_upd) begin
            lock_reg[sect] <= lk_new;
            if (data_reg[fwg_pkg::LK_DOWN]) begin
                lockdown_reg <= 1'b1;
            end
            if (lk_new != lock_reg[sect]) begin
                if (die) begin
                    lock_cnt1_reg <= lk_new ? lock_cnt1_reg + 1'b1
                        : lock_cnt1_reg - 1'b1;
                end else begin
                    lock_cnt0_reg <= lk_new ? lock_cnt0_reg + 1'b1
                        : lock_cnt0_reg - 1'b1;
                end
            end
        end
    end

    // Command result
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            res_reg <= fwg_pkg::RES_OK;
            res_done_reg <= 1'b0;
        end else if (cmd_wr) begin
            res_reg <= res;
            res_done_reg <= 1'b1;
        end
    end

    // Granted array operation, one cycle pulse
    logic [AW-1:0] lo;
    logic [AW-1:0] hi;
    always_comb begin
        lo = addr_reg;
        hi = addr_reg;
        case (op)
            fwg_pkg::OP_PROG: begin
                // one page, independent of its neighbours
                lo = {addr_reg[AW-1:fwg_pkg::PAGE_LSB],
                    {fwg_pkg::PAGE_LSB{1'b0}}};
                hi = {addr_reg[AW-1:fwg_pkg::PAGE_LSB],
                    {fwg_pkg::PAGE_LSB{1'b1}}};
            end
            fwg_pkg::OP_SUB_ERASE: begin
                lo = {addr_reg[AW-1:fwg_pkg::SUB_LSB],
                    {fwg_pkg::SUB_LSB{1'b0}}};
                hi = {addr_reg[AW-1:fwg_pkg::SUB_LSB],
                    {fwg_pkg::SUB_LSB{1'b1}}};
            end
            fwg_pkg::OP_SECT_ERASE: begin
                lo = {sect, {fwg_pkg::SECT_LSB{1'b0}}};
                hi = {sect, {fwg_pkg::SECT_LSB{1'b1}}};
            end
            fwg_pkg::OP_DIE_ERASE: begin
                lo = {die, {(AW-1){1'b0}}};
                hi = {die, {(AW-1){1'b1}}};
            end
            fwg_pkg::OP_OTP_PROG: begin
                lo = {{(AW-fwg_pkg::OTP_W){1'b0}},
                    addr_reg[fwg_pkg::OTP_W-1:0]};
                hi = lo;
            end
            default: begin
                lo = addr_reg;
                hi = addr_reg;
            end
        endcase
    end

    logic is_prog;
    assign is_prog = (op == fwg_pkg::OP_PROG) || (op == fwg_pkg::OP_OTP_PROG);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            op_valid <= 1'b0;
            op_kind <= 4'h0;
            op_otp <= 1'b0;
            op_start <= '0;
            op_end <= '0;
            op_byte <= fwg_pkg::ERASED_BYTE;
        end else begin
            op_valid <= go && op >= fwg_pkg::OP_PROG;
            if (go && op >= fwg_pkg::OP_PROG) begin
                op_kind <= op;
                op_otp <= op == fwg_pkg::OP_OTP_PROG;
                op_start <= lo;
                op_end <= hi;
                // Program can only pull bits low; erase fills with ones
                op_byte <= is_prog ? (cur_byte & data_reg)
                    : fwg_pkg::ERASED_BYTE;
            end
        end
    end

    // APB answer: zero wait states, data prepared in the setup cycle
    logic [31:0] rd;
    logic hit;
    always_comb begin
        rd = 32'h0000_0000;
        hit = 1'b1;
        if (paddr == fwg_pkg::OFF_STATUS) begin
            rd[3:0] = bp_reg;
            rd[fwg_pkg::ST_TB] = tb_reg;
            rd[fwg_pkg::ST_WEL] = wel_reg;
            rd[fwg_pkg::ST_LDN] = lockdown_reg;
            rd[fwg_pkg::ST_RDY] = por_done_reg;
            rd[fwg_pkg::ST_WP] = wp_s2_reg;
        end else if (paddr == fwg_pkg::OFF_ADDR) begin
            rd[AW-1:0] = addr_reg;
        end else if (paddr == fwg_pkg::OFF_DATA) begin
            rd[7:0] = data_reg;
        end else if (paddr == fwg_pkg::OFF_CMD) begin
            rd = 32'h0000_0000;
        end else if (paddr == fwg_pkg::OFF_RESULT) begin
            rd[2:0] = res_reg;
            rd[3] = res_done_reg;
        end else if (paddr == fwg_pkg::OFF_LOCK) begin
            rd[fwg_pkg::LK_LOCK] = lock_reg[sect];
            rd[fwg_pkg::LK_DOWN] = lockdown_reg;
        end else begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~hit;
            if (setup && !pwrite) begin
                prdata <= rd;
            end
        end
    end
endmodule

//--- tb/fwg_guard_props.sv
// Checker for the flash array write guard ports
`timescale 1ns/10ps
module fwg_guard_chk #(
    parameter int POR_CYCLES = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    // Array side
    input wire logic [7:0] cur_byte,
    input wire logic op_valid,
    input wire logic [3:0] op_kind,
    input wire logic op_otp,
    input wire logic [25:0] op_start,
    input wire logic [25:0] op_end,
    input wire logic [7:0] op_byte
);
    int since;
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!nrst);
    // Cycles since reset release, saturating at the inhibit time
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            since <= 0;
        end else if (since < POR_CYCLES) begin
            since <= since + 1;
        end
    end
    AST_READY: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    AST_CAUSE: assert property (op_valid |->
        $past(psel && penable && pready && pwrite && paddr == 8'h0c))
        else $error("grant without command write");
    AST_POR: assert property (since < POR_CYCLES |-> !op_valid)
        else $error("grant during power-on inhibit");
    AST_CLEARS: assert property (op_valid && op_kind == 4'h5 |->
        (op_byte & ~$past(cur_byte)) == 8'h00)
        else $error("program sets a bit");
    AST_ONES: assert property (op_valid && op_kind > 4'h5 &&
        op_kind < 4'h9 |-> op_byte == 8'hff)
        else $error("erase byte not all ones");
    AST_SUB: assert property (op_valid && op_kind == 4'h6 |->
        op_start[11:0] == 12'h0 && op_end == op_start + 26'hfff)
        else $error("subsector span wrong");
    AST_PAGE: assert property (op_valid && op_kind == 4'h5 |->
        op_start[7:0] == 8'h0 && op_end == (op_start | 26'hff))
        else $error("page span wrong");
    AST_SECT: assert property (op_valid && op_kind == 4'h7 |->
        op_start[15:0] == 16'h0 && op_end == (op_start | 26'hffff))
        else $error("sector span wrong");
    AST_DIE: assert property (op_valid && op_kind == 4'h8 |->
        op_start[24:0] == 25'h0 && &op_end[24:0] &&
        op_end[25] == op_start[25])
        else $error("die span wrong");
    AST_OTP: assert property (op_valid && op_otp |->
        op_kind == 4'h9 && op_end[25:6] == 20'h0)
        else $error("otp grant outside otp area");
    cover property (op_valid && op_kind == 4'h8);
    cover property (op_valid && op_otp);
    cover property (op_valid && op_kind == 4'h5);
endmodule
bind fwg_guard fwg_guard_chk #(.POR_CYCLES(POR_CYCLES)) u_chk (.clock,
    .nrst, .psel, .penable, .pwrite, .paddr, .pready, .cur_byte,
    .op_valid, .op_kind, .op_otp, .op_start, .op_end, .op_byte);

//--- tb/fwg_host.sv
// Host controller model issuing guard commands over APB
`timescale 1ns/10ps
module fwg_host (
    // Clock
    input wire logic clock,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, a, d, r, e);
    endtask
    // Modifying command, always preceded by write enable
    task automatic mod(input logic [3:0] op, input logic [25:0] a,
            input logic [7:0] d, input logic [11:0] cnt);
        wr(fwg_pkg::OFF_ADDR, {6'h0, a});
        wr(fwg_pkg::OFF_DATA, {24'h0, d});
        wr(fwg_pkg::OFF_CMD, 32'h81);
        wr(fwg_pkg::OFF_CMD, {16'h0, cnt, op});
    endtask
endmodule

//--- tb/test_flash_array_write_guard.sv
// Self-checking bench for the flash array write guard
`timescale 1ns/10ps
`define CHK(nm, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) begin \
            n_mismatch++; \
            $display("[ERR] %s expected %h seen %h", nm, e, g); \
        end \
    end
module test_flash_array_write_guard;
    localparam int POR = 4;
    logic clock, nrst, psel, penable, pwrite, pready, pslverr, wp_n;
    logic op_valid, op_otp, er;
    logic [7:0] paddr, cur_byte, op_byte;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] op_kind;
    logic [25:0] op_start, op_end;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    fwg_guard #(.POR_CYCLES(POR)) u_dut (.clock, .nrst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wp_n,
        .cur_byte, .op_valid, .op_kind, .op_otp, .op_start, .op_end,
        .op_byte);
    fwg_host u_host (.clock, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic rd_chk(input string nm, input logic [7:0] a,
            input logic [31:0] e);
        u_host.xfer(1'b0, a, 32'h0, rd, er);
        `CHK(nm, e, rd)
    endtask
    task automatic res(input string nm, input logic [2:0] c);
        rd_chk(nm, fwg_pkg::OFF_RESULT, {28'h0, 1'b1, c});
    endtask
    task automatic do_reset;
        nrst <= 1'b0;
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
    endtask
    task automatic t_por;
        u_host.wr(fwg_pkg::OFF_CMD, 32'h81);
        res("por", 3'h1);
        repeat (POR) @(posedge clock);
        rd_chk("status", fwg_pkg::OFF_STATUS, 32'h180);
        u_host.xfer(1'b0, 8'h40, 32'h0, rd, er);
        `CHK("slverr", 1'b1, er)
    endtask
    task automatic t_range;
        int n;
        logic [9:0] s;
        logic p;
        for (int k = 0; k < 32; k++) begin
            n = (k % 16 == 0) ? 0 : (k % 16 > 10) ? 1024
                : 1 << (k % 16 - 1);
            u_host.mod(fwg_pkg::OP_WRSR, 26'h0, 8'(k), 12'h8);
            for (int j = 0; j < 2; j++) begin
                s = (k > 15) ? 10'(n - j) : 10'(1023 - n + j);
                p = (k > 15) ? (s < n) : (s >= 1024 - n);
                u_host.mod(fwg_pkg::OP_SECT_ERASE, {s, 16'h0}, 8'h0, 12'h8);
                res("range", p ? 3'h4 : 3'h0);
                if (!p) `CHK("sector", {s, 16'h0}, op_start)
            end
        end
        u_host.mod(fwg_pkg::OP_WRSR, 26'h0, 8'h0, 12'h8);
    endtask
    task automatic t_prog;
        cur_byte <= 8'h0f;
        u_host.mod(fwg_pkg::OP_PROG, 26'h12345, 8'h3c, 12'h7);
        res("count", 3'h2);
        u_host.wr(fwg_pkg::OFF_CMD, 32'h85);
        res("prog", 3'h0);
        `CHK("byte", 8'h0c, op_byte)
        `CHK("kind", 4'h5, op_kind)
        `CHK("page", 26'h12300, op_start)
        u_host.wr(fwg_pkg::OFF_CMD, 32'h85);
        res("wel", 3'h3);
        u_host.wr(fwg_pkg::OFF_CMD, 32'h81);
        u_host.wr(fwg_pkg::OFF_CMD, 32'h82);
        u_host.wr(fwg_pkg::OFF_CMD, 32'h85);
        res("wrdi", 3'h3);
        u_host.mod(4'ha, 26'h0, 8'h0, 12'h8);
        res("badop", 3'h6);
        u_host.mod(fwg_pkg::OP_SUB_ERASE, 26'h123456, 8'h0, 12'h8);
        res("sub", 3'h0);
        `CHK("subend", 26'h123fff, op_end)
        u_host.mod(fwg_pkg::OP_OTP_PROG, 26'h3f, 8'h0, 12'h8);
        res("otp", 3'h0);
        `CHK("otpflag", 1'b1, op_otp)
        cur_byte <= 8'hff;
    endtask
    task automatic t_lock;
        u_host.mod(fwg_pkg::OP_WRLR, 26'h50000, 8'h1, 12'h8);
        rd_chk("lock", fwg_pkg::OFF_LOCK, 32'h1);
        u_host.mod(fwg_pkg::OP_SECT_ERASE, 26'h50000, 8'h0, 12'h8);
        res("locked", 3'h4);
        u_host.mod(fwg_pkg::OP_DIE_ERASE, 26'h0, 8'h0, 12'h8);
        res("die0", 3'h4);
        u_host.mod(fwg_pkg::OP_DIE_ERASE, 26'h2000000, 8'h0, 12'h8);
        res("die1", 3'h0);
        u_host.mod(fwg_pkg::OP_WRLR, 26'h60000, 8'h2, 12'h8);
        rd_chk("down", fwg_pkg::OFF_LOCK, 32'h2);
        u_host.mod(fwg_pkg::OP_WRLR, 26'h50000, 8'h0, 12'h8);
        res("frozen", 3'h5);
        do_reset();
        repeat (POR + 2) @(posedge clock);
        // Point at the sector that was locked before the reset
        u_host.wr(fwg_pkg::OFF_ADDR, 32'h0005_0000);
        rd_chk("cleared", fwg_pkg::OFF_LOCK, 32'h0);
    endtask
    task automatic t_wp;
        wp_n <= 1'b0;
        repeat (4) @(posedge clock);
        rd_chk("wpstat", fwg_pkg::OFF_STATUS, 32'h80);
        u_host.mod(fwg_pkg::OP_WRSR, 26'h0, 8'h1, 12'h8);
        res("wpsr", 3'h7);
        wp_n <= 1'b1;
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        wp_n = 1'b1;
        cur_byte = 8'hff;
        do_reset();
        t_por();
        t_range();
        t_prog();
        t_lock();
        t_wp();
        summarize();
    end
endmodule
